// ---- logic/crt_defines.svh ----
`ifndef CRT_DEFINES_SVH
`define CRT_DEFINES_SVH

// ****************************************
// register indices, byte address = 4 * index
// ****************************************
`define CRT_IDX_RES_LOW    8'h78
`define CRT_IDX_RES_HIGH   8'h79
`define CRT_IDX_CONV_CTRL  8'h7a
`define CRT_IDX_TRIG_CTRL  8'h7b
`define CRT_IDX_CHAN_SEL   8'h7c
`define CRT_IDX_UPPER_DIS  8'h7d
`define CRT_IDX_LOWER_DIS  8'h7e

// ****************************************
// converter_control field positions
// ****************************************
`define CRT_CC_ENABLE      7
`define CRT_CC_START       6
`define CRT_CC_AUTO        5
`define CRT_CC_DONE        4
`define CRT_CC_IRQ_EN      3

// ****************************************
// channel_select_register field positions
// ****************************************
`define CRT_CS_LEFT_ADJ    6

// ****************************************
// reset values and codes
// ****************************************
`define CRT_RESET_BYTE     8'h00
`define CRT_RESET_RESULT   10'h000
`define CRT_TRIG_FREE      3'h0

`endif

// ---- logic/crt_pkg.sv ----
package crt_pkg;

   // conversion sequencer states, one-hot
   typedef enum logic [1:0]
   {
      CRT_IDLE = 2'b01,
      CRT_BUSY = 2'b10
   } crt_state_type;

   // requests towards the analog core
   typedef struct packed
   {
      logic       enable;
      logic       start;
      logic       abort;
      logic [5:0] channel;
      logic [2:0] prescale;
   } crt_conv_req_type;

   // completion from the analog core
   typedef struct packed
   {
      logic       done;
      logic       differential;
      logic [9:0] data;
   } crt_conv_rsp_type;

endpackage

// ---- logic/crt_trigger.sv ----
`timescale 1ns/100ps
`include "crt_defines.svh"

module crt_trigger
(
   // clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_reset,
   // selection and candidate flags, bit 0 is the done flag
   input  wire logic [2:0] i_sel,
   input  wire logic [7:0] i_sources,
   // rising edge of the selected flag
   output logic            o_edge
);

   // ****************************************
   // edge detection
   // ****************************************
   logic       prev_flag_reg;   // selected flag, one cycle ago
   logic       prev_flag_next;
   logic [2:0] prev_sel_reg;    // selection, one cycle ago
   logic [2:0] prev_sel_next;
   logic       sel_flag;        // flag picked by current selection
   logic       to_free;         // selection just moved to free running

   // mux and compare against last cycle
   always_comb
   begin
      sel_flag       = i_sources[i_sel];
      prev_flag_next = sel_flag;
      prev_sel_next  = i_sel;
      to_free        = (i_sel == `CRT_TRIG_FREE) && (prev_sel_reg != `CRT_TRIG_FREE);
      // a switch between sources counts as an edge, except into free running
      o_edge = sel_flag && !prev_flag_reg && !to_free;
   end

   // history registers
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         prev_flag_reg <= 1'b0;
         prev_sel_reg  <= `CRT_TRIG_FREE;
      end
      else
      begin
         prev_flag_reg <= prev_flag_next;
         prev_sel_reg  <= prev_sel_next;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   a_free_switch: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (i_sel == `CRT_TRIG_FREE && $past(i_sel) != `CRT_TRIG_FREE) |-> !o_edge)
      else $error("switch to free running made a trigger");

   a_edge_source: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      o_edge |-> i_sources[i_sel])
      else $error("trigger edge without selected flag set");

   a_edge_rise: assert property (@(posedge i_sys_clk) disable iff (i_reset)
      (i_sel == $past(i_sel) && $past(i_sources[i_sel]) && o_edge) |-> 1'b0)
      else $error("trigger edge while flag already high");

endmodule

// ---- logic/crt_top.sv ----
// Local design decision: register access over APB.
`timescale 1ns/100ps
`include "crt_defines.svh"

module crt_top
(
   // clock and reset
   input  wire logic                      i_sys_clk,
   input  wire logic                      i_reset,
   // apb slave
   input  wire logic                      i_psel,
   input  wire logic                      i_penable,
   input  wire logic                      i_pwrite,
   input  wire logic [11:0]               i_paddr,
   input  wire logic [31:0]               i_pwdata,
   input  wire logic [3:0]                i_pstrb,
   output logic                           o_pready,
   output logic                           o_pslverr,
   output logic [31:0]                    o_prdata,
   // analog conversion core
   output crt_pkg::crt_conv_req_type      o_conv_req,
   input  wire crt_pkg::crt_conv_rsp_type i_conv_rsp,
   // peripheral flags for trigger codes 1 to 7
   input  wire logic [7:1]                i_trigger_flags,
   // analog pin digital inputs
   input  wire logic [15:0]               i_pin_in,
   output logic [15:0]                    o_pin_value,
   output logic [15:0]                    o_input_disable
);

   // ****************************************
   // bus decode
   // ****************************************
   logic       setup;      // first apb cycle
   logic       wr_acc;     // write takes effect
   logic       rd_acc;     // read side effects
   logic [7:0] idx;        // register index
   logic       hit;        // mapped address
   logic       wr_lane;    // low byte lane written

   // decode from address and phase
   always_comb
   begin
      setup   = i_psel && !i_penable;
      wr_acc  = i_psel && i_penable && i_pwrite;
      rd_acc  = i_psel && i_penable && !i_pwrite;
      idx     = i_paddr[9:2];
      wr_lane = i_pstrb[0];
      // upper address bits and misaligned offsets are unmapped
      hit = (i_paddr[11:10] == 2'h0) && (i_paddr[1:0] == 2'h0) &&
            (idx >= `CRT_IDX_RES_LOW) && (idx <= `CRT_IDX_LOWER_DIS);
   end

   // ****************************************
   // registers
   // ****************************************
   crt_pkg::crt_state_type state_reg;      // conversion sequencer
   crt_pkg::crt_state_type state_next;
   logic        enable_reg;                // converter_enable
   logic        enable_next;
   logic        auto_reg;                  // auto_trigger_enable
   logic        auto_next;
   logic        done_reg;                  // conversion_done_flag
   logic        done_next;
   logic        irq_en_reg;                // stored only, no interrupt here
   logic        irq_en_next;
   logic [2:0]  prescale_reg;              // core clock divider select
   logic [2:0]  prescale_next;
   logic [6:0]  chan_reg;                  // left adjust and channel_select_bits
   logic [6:0]  chan_next;
   logic [2:0]  trig_sel_reg;              // trigger_source_select
   logic [2:0]  trig_sel_next;
   logic [7:0]  lower_dis_reg;             // lower_pin_disable_bits
   logic [7:0]  lower_dis_next;
   logic [7:0]  upper_dis_reg;             // upper_pin_disable_bits
   logic [7:0]  upper_dis_next;
   logic [9:0]  result_reg;                // conversion_result
   logic [9:0]  result_next;
   logic        lock_reg;                  // low byte read, high pending
   logic        lock_next;
   logic        start_reg;                 // start pulse to core
   logic        start_next;
   logic        abort_reg;                 // abort pulse to core
   logic        abort_next;
   logic [7:0]  rd_byte_reg;               // read data
   logic [7:0]  rd_byte_next;
   logic        err_reg;                   // unmapped address answer
   logic        err_next;
   logic [15:0] pin_reg;                   // masked pin values
   logic [15:0] pin_next;

   // ****************************************
   // trigger edge unit
   // ****************************************
   logic trig_edge;   // selected flag rose

   crt_trigger u_trigger
   (
      .i_sys_clk (i_sys_clk),
      .i_reset   (i_reset),
      .i_sel     (trig_sel_reg),
      .i_sources ({i_trigger_flags, done_reg}),
      .o_edge    (trig_edge)
   );

   // ****************************************
   // next values
   // ****************************************
   logic       busy;        // conversion in progress
   logic       sw_start;    // start bit written as one
   logic       auto_start;  // trigger edge accepted
   logic       finish;      // core reports completion
   logic [9:0] encoded;     // result as it will be stored
   logic       left;        // left adjust select

   // control, result and read path
   always_comb
   begin
      busy           = (state_reg == crt_pkg::CRT_BUSY);
      left           = chan_reg[`CRT_CS_LEFT_ADJ];
      enable_next    = enable_reg;
      auto_next      = auto_reg;
      irq_en_next    = irq_en_reg;
      prescale_next  = prescale_reg;
      chan_next      = chan_reg;
      trig_sel_next  = trig_sel_reg;
      lower_dis_next = lower_dis_reg;
      upper_dis_next = upper_dis_reg;
      done_next      = done_reg;
      sw_start       = 1'b0;
      // register writes, low byte lane only, aliases and misaligned refused
      if (wr_acc && wr_lane && hit)
      begin
         case (idx)
            `CRT_IDX_CONV_CTRL:
            begin
               enable_next   = i_pwdata[`CRT_CC_ENABLE];
               sw_start      = i_pwdata[`CRT_CC_START];
               auto_next     = i_pwdata[`CRT_CC_AUTO];
               irq_en_next   = i_pwdata[`CRT_CC_IRQ_EN];
               prescale_next = i_pwdata[2:0];
               // writing one clears the done flag
               if (i_pwdata[`CRT_CC_DONE])
               begin
                  done_next = 1'b0;
               end
            end
            `CRT_IDX_CHAN_SEL:  chan_next      = i_pwdata[6:0];
            // reserved bits 7 to 3 are not stored, read zero
            `CRT_IDX_TRIG_CTRL: trig_sel_next  = i_pwdata[2:0];
            `CRT_IDX_LOWER_DIS: lower_dis_next = i_pwdata[7:0];
            `CRT_IDX_UPPER_DIS: upper_dis_next = i_pwdata[7:0];
            default:            done_next      = done_reg;
         endcase
      end
      // edges only count with auto trigger on and nothing running
      auto_start = auto_reg && trig_edge && !busy;
      finish     = busy && i_conv_rsp.done;
      // differential results flip the offset msb into a sign bit
      encoded = i_conv_rsp.differential ?
                {~i_conv_rsp.data[9], i_conv_rsp.data[8:0]} :
                i_conv_rsp.data;
      state_next  = state_reg;
      start_next  = 1'b0;
      abort_next  = 1'b0;
      result_next = result_reg;
      case (state_reg)
         crt_pkg::CRT_IDLE:
         begin
            // start allowed in the same write that enables
            if (enable_next && (sw_start || auto_start))
            begin
               start_next = 1'b1;
               state_next = crt_pkg::CRT_BUSY;
            end
         end
         crt_pkg::CRT_BUSY:
         begin
            if (!enable_next)
            begin
               abort_next = 1'b1;
               state_next = crt_pkg::CRT_IDLE;
            end
            else if (finish)
            begin
               state_next = crt_pkg::CRT_IDLE;
               done_next  = 1'b1;
               // a pending high read keeps the old pair intact
               if (!lock_reg)
               begin
                  result_next = encoded;
               end
            end
         end
         default: state_next = crt_pkg::CRT_IDLE;
      endcase
      // read order lock
      lock_next = lock_reg;
      if (rd_acc && hit && idx == `CRT_IDX_RES_LOW)
      begin
         lock_next = 1'b1;
      end
      else if (rd_acc && hit && idx == `CRT_IDX_RES_HIGH)
      begin
         lock_next = 1'b0;
      end
      // read data captured in the setup cycle
      rd_byte_next = rd_byte_reg;
      err_next     = err_reg;
      if (setup)
      begin
         err_next = !hit;
         // unmapped aliases fall to the default and read zero
         case (hit ? idx : 8'h00)
            `CRT_IDX_RES_LOW:
               rd_byte_next = left ? {result_reg[1:0], 6'h00} :
                                     result_reg[7:0];
            `CRT_IDX_RES_HIGH:
               rd_byte_next = left ? result_reg[9:2] :
                                     {6'h00, result_reg[9:8]};
            `CRT_IDX_CONV_CTRL:
               rd_byte_next = {enable_reg, busy, auto_reg, done_reg,
                               irq_en_reg, prescale_reg};
            `CRT_IDX_CHAN_SEL:  rd_byte_next = {1'b0, chan_reg};
            `CRT_IDX_TRIG_CTRL: rd_byte_next = {5'h00, trig_sel_reg};
            `CRT_IDX_LOWER_DIS: rd_byte_next = lower_dis_reg;
            `CRT_IDX_UPPER_DIS: rd_byte_next = upper_dis_reg;
            default:            rd_byte_next = `CRT_RESET_BYTE;
         endcase
      end
      // disabled buffers read as zero
      pin_next = i_pin_in & ~{upper_dis_reg, lower_dis_reg};
   end

   // ****************************************
   // state registers
   // ****************************************
   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         state_reg     <= crt_pkg::CRT_IDLE;
         enable_reg    <= 1'b0;
         auto_reg      <= 1'b0;
         done_reg      <= 1'b0;
         irq_en_reg    <= 1'b0;
         prescale_reg  <= 3'h0;
         chan_reg      <= 7'h00;
         trig_sel_reg  <= `CRT_TRIG_FREE;
         lower_dis_reg <= `CRT_RESET_BYTE;
         upper_dis_reg <= `CRT_RESET_BYTE;
         result_reg    <= `CRT_RESET_RESULT;
         lock_reg      <= 1'b0;
         start_reg     <= 1'b0;
         abort_reg     <= 1'b0;
         rd_byte_reg   <= `CRT_RESET_BYTE;
         err_reg       <= 1'b0;
         pin_reg       <= 16'h0000;
      end
      else
      begin
         state_reg     <= state_next;
         enable_reg    <= enable_next;
         auto_reg      <= auto_next;
         done_reg      <= done_next;
         irq_en_reg    <= irq_en_next;
         prescale_reg  <= prescale_next;
         chan_reg      <= chan_next;
         trig_sel_reg  <= trig_sel_next;
         lower_dis_reg <= lower_dis_next;
         upper_dis_reg <= upper_dis_next;
         result_reg    <= result_next;
         lock_reg      <= lock_next;
         start_reg     <= start_next;
         abort_reg     <= abort_next;
         rd_byte_reg   <= rd_byte_next;
         err_reg       <= err_next;
         pin_reg       <= pin_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // zero wait states: data was fetched in setup
   assign o_pready        = 1'b1;
   assign o_pslverr       = err_reg && i_psel && i_penable;
   assign o_prdata        = {24'h000000, rd_byte_reg};
   assign o_pin_value     = pin_reg;
   assign o_input_disable = {upper_dis_reg, lower_dis_reg};
   assign o_conv_req      = '{enable:   enable_reg,
                              start:    start_reg,
                              abort:    abort_reg,
                              channel:  chan_reg[5:0],
                              prescale: prescale_reg};

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   a_result_encode: assert property (
      (finish && enable_next && !lock_reg) |=> (result_reg == $past(encoded)))
      else $error("result not stored on completion");

   a_lock_holds: assert property (
      (lock_reg && !(rd_acc && idx == `CRT_IDX_RES_HIGH)) |=> $stable(result_reg))
      else $error("result changed while high byte pending");

   a_left_read: assert property (
      (setup && hit && idx == `CRT_IDX_RES_HIGH && left) |=>
      (o_prdata[7:0] == $past(result_reg[9:2])))
      else $error("left adjusted high byte wrong");

   a_right_read: assert property (
      (setup && hit && idx == `CRT_IDX_RES_LOW && !left) |=>
      (o_prdata[7:0] == $past(result_reg[7:0])))
      else $error("right adjusted low byte wrong");

   a_no_auto: assert property (
      (!auto_reg && !sw_start) |=> !start_reg)
      else $error("start without auto trigger or software");

   a_auto_start: assert property (
      (auto_reg && trig_edge && !busy && enable_next) |=> start_reg ##1 busy)
      else $error("selected edge did not start conversion");

   a_lower_mask: assert property (
      ##1 ((o_pin_value[7:0] & $past(lower_dis_reg)) == 8'h00))
      else $error("disabled lower pin read as one");

   a_upper_mask: assert property (
      ##1 ((o_pin_value[15:8] & $past(upper_dis_reg)) == 8'h00))
      else $error("disabled upper pin read as one");

   a_done_flag: assert property (
      (finish && enable_next) |=> done_reg)
      else $error("done flag not set on completion");

   a_abort: assert property (
      (busy && !enable_next) |=> (abort_reg && !busy))
      else $error("disable during conversion did not abort");

   a_busy_drop: assert property (
      busy |=> !start_reg)
      else $error("start issued during a conversion");

endmodule

// ---- verification/crt_core_model.sv ----
`timescale 1ns/100ps

module crt_core_model
(
   // clock and reset
   input  wire logic                      i_sys_clk,
   input  wire logic                      i_reset,
   // requests from the block, knobs from the bench
   input  wire crt_pkg::crt_conv_req_type i_req,
   input  wire logic [7:0]                i_latency,
   input  wire logic                      i_diff,
   input  wire logic [9:0]                i_data,
   // completion back to the block
   output crt_pkg::crt_conv_rsp_type      o_rsp
);
   logic [7:0] cnt_reg;   // cycles left in the conversion
   logic       busy_reg;  // conversion running

   // ****************************************
   // conversion timing
   // ****************************************
   // outside the done pulse the result lines toggle, so stale data never looks valid
   always @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         busy_reg <= 1'b0;
         cnt_reg  <= 8'h00;
         o_rsp    <= '0;
      end
      else
      begin
         o_rsp.done         <= 1'b0;
         o_rsp.data         <= ~o_rsp.data;
         o_rsp.differential <= ~o_rsp.differential;
         if (i_req.abort || !i_req.enable)
            busy_reg <= 1'b0;
         else if (i_req.start && !busy_reg)
         begin
            busy_reg <= 1'b1;
            cnt_reg  <= i_latency;
         end
         else if (busy_reg && cnt_reg <= 8'h01)
         begin
            // raw code, offset binary when differential
            busy_reg           <= 1'b0;
            o_rsp.done         <= 1'b1;
            o_rsp.data         <= i_data;
            o_rsp.differential <= i_diff;
         end
         else if (busy_reg)
            cnt_reg <= cnt_reg - 8'h01;
      end
   end
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/100ps

module tb;
   logic                      clk, rst, psel, penable, pwrite, pready, pslverr, diff, err_seen;
   logic [11:0]               paddr;
   logic [31:0]               pwdata, prdata;
   logic [3:0]                pstrb;
   logic [7:1]                flags;
   logic [15:0]               pin_in, pin_val, in_dis;
   logic [7:0]                lat, rd;
   logic [9:0]                cdata;
   crt_pkg::crt_conv_req_type req;
   crt_pkg::crt_conv_rsp_type rsp;
   int                        error_cnt, cmp_count, starts, aborts, s, a;

   crt_top dut_u (.i_sys_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
      .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata), .o_conv_req(req),
      .i_conv_rsp(rsp), .i_trigger_flags(flags), .i_pin_in(pin_in),
      .o_pin_value(pin_val), .o_input_disable(in_dis));
   crt_core_model core_u (.i_sys_clk(clk), .i_reset(rst), .i_req(req), .i_latency(lat),
      .i_diff(diff), .i_data(cdata), .o_rsp(rsp));

   // ****************************************
   // clock and event counters
   // ****************************************
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // start and abort pulses last one cycle, so each edge sees one at most
   always @(posedge clk)
   begin
      if (req.start === 1'b1) starts++;
      if (req.abort === 1'b1) aborts++;
   end

   // ****************************************
   // checking and bus tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // entered right after an edge; ends one idle edge after the access edge
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= {2'b00, idx, 2'b00};
      pwdata  <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin error_cnt++; give_verdict(); end
      rd       = prdata[7:0];
      err_seen = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk($sformatf("reg %h", idx), {24'h0, exp}, prdata);
   endtask
   // polls the done flag; gives up after a bounded number of reads
   task automatic wait_done();
      int n;
      n = 0;
      do begin apb(1'b0, 8'h7a, 8'h00); n++; end while (rd[4] !== 1'b1 && n < 40);
      if (rd[4] !== 1'b1) begin error_cnt++; give_verdict(); end
   endtask
   task automatic convert(input logic [9:0] d, input logic df);
      cdata <= d;
      diff  <= df;
      apb(1'b1, 8'h7a, 8'hd0);   // enable, start, clear done
      wait_done();
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, diff, cdata, flags} = '0;
      pstrb = 4'hf;
      pin_in = 16'hffff;
      lat = 8'h04;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // reset values and register access
      rdc(8'h78, 8'h00);
      rdc(8'h79, 8'h00);
      rdc(8'h7d, 8'h00);
      rdc(8'h7e, 8'h00);
      apb(1'b0, 8'h70, 8'h00);
      chk("unmapped error", 1, err_seen);
      apb(1'b1, 8'h7e, 8'ha5);
      apb(1'b1, 8'h7d, 8'h3c);
      pstrb <= 4'h0;
      apb(1'b1, 8'h7e, 8'hff);   // no byte strobe, so ignored
      pstrb <= 4'hf;
      rdc(8'h7e, 8'ha5);
      chk("input disable", 16'h3ca5, in_dis);
      chk("pin value", 16'hc35a, pin_val);
      // channel and prescale reach the core request, irq enable only reads back
      apb(1'b1, 8'h7c, 8'h2a);
      apb(1'b1, 8'h7a, 8'h0b);
      rdc(8'h7c, 8'h2a);
      rdc(8'h7a, 8'h0b);
      chk("core req", 12'h153, {req.enable, req.start, req.abort, req.channel, req.prescale});
      $display("test registers done");
      // result layout; low byte always read first
      convert(10'h2b7, 1'b0);
      apb(1'b1, 8'h78, 8'hff);   // result is read only
      rdc(8'h78, 8'hb7);
      rdc(8'h79, 8'h02);
      apb(1'b1, 8'h7c, 8'h40);
      rdc(8'h78, 8'hc0);
      rdc(8'h79, 8'had);
      apb(1'b1, 8'h7c, 8'h00);
      convert(10'h080, 1'b1);
      rdc(8'h78, 8'h80);
      rdc(8'h79, 8'h02);
      $display("test result layout done");
      // lock: a result finishing between the two byte reads is lost
      apb(1'b0, 8'h78, 8'h00);
      convert(10'h155, 1'b0);
      rdc(8'h79, 8'h02);
      convert(10'h155, 1'b0);
      rdc(8'h78, 8'h55);
      rdc(8'h79, 8'h01);
      $display("test read lock done");
      // every peripheral trigger code 1 to 7, and a foreign flag that must not trigger
      for (int k = 1; k < 8; k++)
      begin
         apb(1'b1, 8'h7a, 8'hb0);   // enable, auto, clear done
         apb(1'b1, 8'h7b, 8'(k));
         rdc(8'h7b, 8'(k));
         s = starts;
         flags[(k % 7) + 1] <= 1'b1;
         repeat (3) @(posedge clk);
         chk("foreign flag", s, starts);
         flags <= '0;
         @(posedge clk);
         flags[k] <= 1'b1;
         repeat (3) @(posedge clk);
         chk("selected flag", s + 1, starts);
         wait_done();
         flags <= '0;
      end
      // auto off: selection has no effect
      apb(1'b1, 8'h7a, 8'h90);
      apb(1'b1, 8'h7b, 8'h03);
      s = starts;
      flags[3] <= 1'b1;
      repeat (3) @(posedge clk);
      chk("auto off", s, starts);
      flags <= '0;
      // switching from a clear source to a set one
      apb(1'b1, 8'h7a, 8'hb0);
      apb(1'b1, 8'h7b, 8'h04);
      flags[5] <= 1'b1;
      s = starts;
      apb(1'b1, 8'h7b, 8'h05);
      repeat (3) @(posedge clk);
      chk("select switch", s + 1, starts);
      wait_done();
      flags <= '0;
      // done flag already set: free running selection is no event
      s = starts;
      apb(1'b1, 8'h7b, 8'h00);
      repeat (3) @(posedge clk);
      chk("free select", s, starts);
      $display("test trigger sources done");
      // trigger while busy is dropped
      lat <= 8'h14;
      apb(1'b1, 8'h7a, 8'hb0);
      apb(1'b1, 8'h7b, 8'h01);
      s = starts;
      flags[1] <= 1'b1;
      repeat (3) @(posedge clk);
      flags[1] <= 1'b0;
      repeat (2) @(posedge clk);
      flags[1] <= 1'b1;
      repeat (3) @(posedge clk);
      chk("busy trigger", s + 1, starts);
      wait_done();
      flags <= '0;
      // free running: done rising restarts, then disable aborts
      apb(1'b1, 8'h7b, 8'h00);
      s = starts;
      a = aborts;
      apb(1'b1, 8'h7a, 8'hf0);
      wait_done();
      repeat (3) @(posedge clk);
      chk("free restart", s + 2, starts);
      apb(1'b1, 8'h7a, 8'h10);
      repeat (3) @(posedge clk);
      chk("abort pulse", a + 1, aborts);
      repeat (30) @(posedge clk);
      rdc(8'h7a, 8'h00);
      $display("test busy and abort done");
      give_verdict();
   end
endmodule
